// [srs_pkg.sv]
// package: options, timing constants and states for the supply reset supervisor
package srs_pkg;

	// timeout option selector values
	localparam logic [2:0] SRS_TIMEOUT_OPTION_0 = 3'h0;
	localparam logic [2:0] SRS_TIMEOUT_OPTION_1 = 3'h1;
	localparam logic [2:0] SRS_TIMEOUT_OPTION_2 = 3'h2;
	localparam logic [2:0] SRS_TIMEOUT_OPTION_3 = 3'h3;
	localparam logic [2:0] SRS_TIMEOUT_OPTION_4 = 3'h4;

	// output style selector values
	localparam logic [1:0] SRS_OUT_PUSH_LOW  = 2'h0;
	localparam logic [1:0] SRS_OUT_PUSH_HIGH = 2'h1;
	localparam logic [1:0] SRS_OUT_OPEN_LOW  = 2'h2;

	// clock rate
	localparam int SRS_CLK_HZ = 25000000;

	// typical hold times in microseconds
	localparam real SRS_HOLD0_US = 70.0;
	localparam real SRS_HOLD1_US = 1500.0;
	localparam real SRS_HOLD2_US = 30000.0;
	localparam real SRS_HOLD3_US = 210000.0;
	localparam real SRS_HOLD4_US = 1680000.0;

	// hold times in cycles (every time rounds down)
	localparam int SRS_HOLD0_CYC = int'($floor(SRS_HOLD0_US * SRS_CLK_HZ / 1.0e6));
	localparam int SRS_HOLD1_CYC = int'($floor(SRS_HOLD1_US * SRS_CLK_HZ / 1.0e6));
	localparam int SRS_HOLD2_CYC = int'($floor(SRS_HOLD2_US * SRS_CLK_HZ / 1.0e6));
	localparam int SRS_HOLD3_CYC = int'($floor(SRS_HOLD3_US * SRS_CLK_HZ / 1.0e6));
	localparam int SRS_HOLD4_CYC = int'($floor(SRS_HOLD4_US * SRS_CLK_HZ / 1.0e6));

	// glitch rejection on the manual reset input, nanoseconds
	localparam real SRS_MANUAL_GLITCH_NS = 100.0;
	localparam int  SRS_MANUAL_GLITCH_CYC =
		int'($ceil(SRS_MANUAL_GLITCH_NS * SRS_CLK_HZ / 1.0e9));

	// supply dip rejection, microseconds
	localparam real SRS_SUPPLY_FILTER_US = 60.0;
	localparam int  SRS_SUPPLY_FILTER_CYC =
		int'($ceil(SRS_SUPPLY_FILTER_US * SRS_CLK_HZ / 1.0e6));

	// counter widths
	localparam int SRS_HOLD_W   = 26;
	localparam int SRS_FILTER_W = 12;

	// supervisor states, gray along the usual path
	typedef enum logic [1:0]
	{
		SRS_ST_ASSERT = 2'b00,
		SRS_ST_HOLD   = 2'b01,
		SRS_ST_IDLE   = 2'b11
	} srs_state_t;

endpackage

// [srs_filter_if.sv]
// interface: link between supervisor and its input filters
interface srs_filter_if;
	logic raw_low;
	logic clean_low;
	modport filt (input raw_low, output clean_low);
	modport user (output raw_low, input clean_low);
endinterface

// [srs_low_filter.sv]
// filter: passes a low level only after it stood a given number of cycles
module srs_low_filter
	import srs_pkg::*;
#(
	parameter int LOW_CYCLES = 3
)
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// filtered signal
	srs_filter_if.filt fi
);

	logic [SRS_FILTER_W-1:0] cnt_reg;
	logic                    clean_reg;

	//////////////////////////////////////////////////////////////////////////
	// short lows are dropped; highs clear at once so release is prompt
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_reg   <= '0;
			clean_reg <= 1'b0;
		end
		else if (!fi.raw_low)
		begin
			cnt_reg   <= '0;
			clean_reg <= 1'b0;
		end
		else if (cnt_reg >= SRS_FILTER_W'(LOW_CYCLES - 1))
			clean_reg <= 1'b1;
		else
			cnt_reg <= cnt_reg + SRS_FILTER_W'(1);
	end

	assign fi.clean_low = clean_reg;

endmodule

// [supply_reset_supervisor.sv]
// top: supply reset supervisor with hold timeout; every output style driven at once, output_style unused
module supply_reset_supervisor
	import srs_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// build options
	input  wire logic [2:0] timeout_option,
	input  wire logic [1:0] output_style,
	input  wire logic       sense_mode,
	// comparator and pin inputs
	input  wire logic       supply_low,
	input  wire logic       sense_low,
	input  wire logic       manual_reset_n,
	// reset outputs
	output logic            reset_out_n,
	output logic            reset_out,
	output logic            reset_od_o,
	output logic            reset_od_oe,
	output logic            reset_active
);

	//////////////////////////////////////////////////////////////////////////
	// two-flop synchronisers for asynchronous inputs
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
		end
		else
		begin
			sync1_reg <= {sense_low, supply_low, ~manual_reset_n};
			sync2_reg <= sync1_reg;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// filters on manual and comparator paths
	srs_filter_if man_if ();
	srs_filter_if cmp_if ();

	assign man_if.raw_low = sync2_reg[0];

	assign cmp_if.raw_low = sense_mode ? sync2_reg[2] : sync2_reg[1];

	srs_low_filter #(.LOW_CYCLES(SRS_MANUAL_GLITCH_CYC)) u_man_filt
	(
		.clk (clk),
		.rst (rst),
		.fi  (man_if.filt)
	);

	srs_low_filter #(.LOW_CYCLES(SRS_SUPPLY_FILTER_CYC)) u_cmp_filt
	(
		.clk (clk),
		.rst (rst),
		.fi  (cmp_if.filt)
	);

	logic cause;

	assign cause = man_if.clean_low | cmp_if.clean_low;

	//////////////////////////////////////////////////////////////////////////
	// hold length from option; unused codes fall back to the shortest
	logic [SRS_HOLD_W-1:0] hold_len;

	always_comb
	begin
		unique case (timeout_option)
			SRS_TIMEOUT_OPTION_0: hold_len = SRS_HOLD_W'(SRS_HOLD0_CYC);
			SRS_TIMEOUT_OPTION_1: hold_len = SRS_HOLD_W'(SRS_HOLD1_CYC);
			SRS_TIMEOUT_OPTION_2: hold_len = SRS_HOLD_W'(SRS_HOLD2_CYC);
			SRS_TIMEOUT_OPTION_3: hold_len = SRS_HOLD_W'(SRS_HOLD3_CYC);
			SRS_TIMEOUT_OPTION_4: hold_len = SRS_HOLD_W'(SRS_HOLD4_CYC);
			default:              hold_len = SRS_HOLD_W'(SRS_HOLD0_CYC);
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// state machine; powers up asserted so the system starts held
	srs_state_t            state_reg;
	logic [SRS_HOLD_W-1:0] cnt_reg;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_reg <= SRS_ST_ASSERT;
			cnt_reg   <= '0;
		end
		else
		begin
			unique case (state_reg)
				SRS_ST_ASSERT:
				begin
					cnt_reg <= '0;
					if (!cause)
						state_reg <= SRS_ST_HOLD;
				end
				SRS_ST_HOLD:
				begin
					if (cause)
					begin
						state_reg <= SRS_ST_ASSERT;
						cnt_reg   <= '0;
					end
					else if (cnt_reg >= hold_len - SRS_HOLD_W'(1))
						state_reg <= SRS_ST_IDLE;
					else
						cnt_reg <= cnt_reg + SRS_HOLD_W'(1);
				end
				SRS_ST_IDLE:
				begin
					cnt_reg <= '0;
					if (cause)
						state_reg <= SRS_ST_ASSERT;
				end
				default:
				begin
					state_reg <= SRS_ST_ASSERT;
					cnt_reg   <= '0;
				end
			endcase
		end
	end

	logic asserting;

	assign asserting = (state_reg != SRS_ST_IDLE) || cause;

	//////////////////////////////////////////////////////////////////////////
	// registered outputs; all styles driven, board picks one
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			reset_out_n  <= 1'b0;
			reset_out    <= 1'b1;
			reset_od_o   <= 1'b0;
			reset_od_oe  <= 1'b1;
			reset_active <= 1'b1;
		end
		else
		begin
			reset_out_n  <= ~asserting;
			reset_out    <= asserting;
			reset_od_o   <= 1'b0;
			reset_od_oe  <= asserting;
			reset_active <= asserting;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// check helpers; counted apart from the filters and hold counter they judge
	logic [SRS_FILTER_W-1:0] man_run_reg;
	logic [SRS_FILTER_W-1:0] cmp_run_reg;
	logic [SRS_HOLD_W-1:0]   quiet_reg;

	always_ff @(posedge clk)
	begin
		if (rst || !man_if.raw_low)
			man_run_reg <= '0;
		else if (man_run_reg != SRS_FILTER_W'(SRS_MANUAL_GLITCH_CYC))
			man_run_reg <= man_run_reg + SRS_FILTER_W'(1);
	end

	always_ff @(posedge clk)
	begin
		if (rst || !cmp_if.raw_low)
			cmp_run_reg <= '0;
		else if (cmp_run_reg != SRS_FILTER_W'(SRS_SUPPLY_FILTER_CYC))
			cmp_run_reg <= cmp_run_reg + SRS_FILTER_W'(1);
	end

	// cycles since last cause; saturates so a long idle cannot wrap
	always_ff @(posedge clk)
	begin
		if (rst || cause)
			quiet_reg <= '0;
		else if (quiet_reg != '1)
			quiet_reg <= quiet_reg + SRS_HOLD_W'(1);
	end

	//////////////////////////////////////////////////////////////////////////
	// checks

	chk_man_filter_len: assert property (
		@(posedge clk) disable iff (rst)
		man_if.clean_low == (man_run_reg == SRS_FILTER_W'(SRS_MANUAL_GLITCH_CYC)))
		else $error("manual filter length wrong");

	chk_cmp_filter_len: assert property (
		@(posedge clk) disable iff (rst)
		cmp_if.clean_low == (cmp_run_reg == SRS_FILTER_W'(SRS_SUPPLY_FILTER_CYC)))
		else $error("comparator filter length wrong");

	chk_hold_quiet: assert property (
		@(posedge clk) disable iff (rst)
		(state_reg == SRS_ST_IDLE && $past(state_reg) == SRS_ST_HOLD)
		|-> quiet_reg == hold_len + SRS_HOLD_W'(1))
		else $error("hold length differs from quiet time");

	chk_hold_ends: assert property (
		@(posedge clk) disable iff (rst)
		(state_reg == SRS_ST_HOLD && !cause && quiet_reg == hold_len)
		|=> state_reg == SRS_ST_IDLE)
		else $error("hold did not end after timeout");

	chk_release_late: assert property (
		@(posedge clk) disable iff (rst)
		$rose(reset_out_n) |-> $past(quiet_reg) > hold_len)
		else $error("active-low output released early");

	chk_high_release: assert property (
		@(posedge clk) disable iff (rst)
		$fell(reset_out) |-> $past(quiet_reg) > hold_len)
		else $error("active-high output released early");

	chk_cause_asserts: assert property (
		@(posedge clk) disable iff (rst)
		cause |=> reset_active)
		else $error("cause present but reset not asserted");

	chk_hold_restart: assert property (
		@(posedge clk) disable iff (rst)
		(state_reg == SRS_ST_HOLD && cause) |=> state_reg == SRS_ST_ASSERT)
		else $error("cause during hold did not restart");

	chk_hold_no_early: assert property (
		@(posedge clk) disable iff (rst)
		(state_reg == SRS_ST_IDLE && $past(state_reg) == SRS_ST_HOLD)
		|-> $past(cnt_reg) >= hold_len - SRS_HOLD_W'(1))
		else $error("hold ended early");

	chk_polarity_pair: assert property (
		@(posedge clk) disable iff (rst)
		reset_out_n == ~reset_out)
		else $error("output polarities disagree");

	chk_high_follows: assert property (
		@(posedge clk) disable iff (rst)
		$rose(cause) |=> ##[0:1] reset_out)
		else $error("active-high output missed reset");

	chk_od_low_only: assert property (
		@(posedge clk) disable iff (rst)
		!reset_od_o && (reset_od_oe == reset_active))
		else $error("open drain drove high or enable wrong");

	chk_manual_holds: assert property (
		@(posedge clk) disable iff (rst)
		man_if.clean_low |=> (state_reg == SRS_ST_ASSERT) && reset_active)
		else $error("manual low did not hold reset");

	chk_glitch_reject: assert property (
		@(posedge clk) disable iff (rst)
		$rose(man_if.raw_low) ##1 !man_if.raw_low |-> !man_if.clean_low)
		else $error("manual glitch passed filter");

	chk_dip_filter: assert property (
		@(posedge clk) disable iff (rst)
		$rose(cmp_if.clean_low) |-> $past(cmp_if.raw_low, 2))
		else $error("supply dip passed too fast");

	chk_sense_select: assert property (
		@(posedge clk) disable iff (rst)
		sense_mode |-> cmp_if.raw_low == sync2_reg[2])
		else $error("sense mode watched the supply");

	chk_option_len: assert property (
		@(posedge clk) disable iff (rst)
		timeout_option == SRS_TIMEOUT_OPTION_1
		|-> hold_len == SRS_HOLD_W'(SRS_HOLD1_CYC))
		else $error("timeout option length wrong");

endmodule

// [srs_host_model.sv]
// host model: reset pin receiver with pull-up on the open-drain line
module srs_host_model
(
	// open-drain pin
	input  wire logic od_o,
	input  wire logic od_oe,
	// resolved pin level
	output logic      pin_level
);
	timeunit 1ns;
	timeprecision 1ps;
	assign pin_level = od_oe ? od_o : 1'b1;
endmodule

// [test_supply_reset_supervisor.sv]
// testbench: random and corner stimulus for the supply reset supervisor
module test_supply_reset_supervisor
	import srs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk;
	logic       rst;
	logic [2:0] timeout_option;
	logic [1:0] output_style;
	logic       sense_mode;
	logic       supply_low;
	logic       sense_low;
	logic       manual_reset_n;
	logic       reset_out_n;
	logic       reset_out;
	logic       reset_od_o;
	logic       reset_od_oe;
	logic       reset_active;
	logic       pin_level;
	int         errors;
	int         n_compared;
	int         t;
	supply_reset_supervisor i_supply_reset_supervisor (.clk(clk), .rst(rst),
		.timeout_option(timeout_option), .output_style(output_style), .sense_mode(sense_mode),
		.supply_low(supply_low), .sense_low(sense_low), .manual_reset_n(manual_reset_n),
		.reset_out_n(reset_out_n), .reset_out(reset_out), .reset_od_o(reset_od_o),
		.reset_od_oe(reset_od_oe), .reset_active(reset_active));
	srs_host_model i_srs_host_model (.od_o(reset_od_o), .od_oe(reset_od_oe),
		.pin_level(pin_level));
	initial clk = 1'b0;
	always #20 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	function automatic int exp_hold(input logic [2:0] o);
		case (o)
			3'h1: return SRS_HOLD1_CYC;
			3'h2: return SRS_HOLD2_CYC;
			3'h3: return SRS_HOLD3_CYC;
			3'h4: return SRS_HOLD4_CYC;
			default: return SRS_HOLD0_CYC;
		endcase
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// w: 0 supply, 1 sense, 2 manual; others stay clear
	task automatic cause(input int w, input int n);
		cyc(1);
		{manual_reset_n, sense_low, supply_low} <= (w == 2) ? 3'h0 : (w == 1) ? 3'h6 : 3'h5;
		cyc(n);
	endtask
	task automatic clear();
		cyc(1);
		{manual_reset_n, sense_low, supply_low} <= 3'h4;
	endtask
	task automatic chk_rst(input logic e);
		#1;
		n_compared++;
		if (reset_active !== e || reset_out !== e || reset_out_n !== ~e ||
			reset_od_oe !== e || reset_od_o !== 1'b0 || pin_level !== ~e)
		begin
			errors++;
			$display("MISMATCH %0t reset outputs not %b", $time, e);
		end
	endtask
	// small slack covers sync, filter release and output register
	task automatic chk_hold();
		int n;
		int x;
		n = 0;
		x = exp_hold(timeout_option);
		while (reset_active !== 1'b0 && n < x + 100)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		n_compared++;
		if (n < x || n > x + 15)
		begin
			errors++;
			$display("MISMATCH %0t hold of %0d cycles", $time, n);
		end
	endtask
	task automatic test_done();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#(80000 * 40);
		errors++;
		test_done();
	end
	initial
	begin
		errors = 0;
		n_compared = 0;
		rst = 1'b1;
		timeout_option = 3'h0;
		output_style = 2'h0;
		sense_mode = 1'b0;
		{manual_reset_n, sense_low, supply_low} = 3'h4;
		void'($urandom(63799));
		cyc(5);
		rst <= 1'b0;
		chk_rst(1'b1);
		chk_hold();
		repeat (4)
		begin
			cyc(1);
			t = $urandom_range(0, 3);
			timeout_option <= (t == 0) ? 3'h0 : 3'(t + 4);
			output_style <= 2'($urandom_range(0, 2));
			cause(2, $urandom_range(0, 1));
			clear();
			cyc(10);
			chk_rst(1'b0);
			cause(2, 8);
			chk_rst(1'b1);
			cyc($urandom_range(45, 70));
			chk_rst(1'b1);
			clear();
			chk_hold();
		end
		cause(0, 1000);
		clear();
		cyc(1600);
		chk_rst(1'b0);
		cause(0, 1510);
		chk_rst(1'b1);
		clear();
		chk_hold();
		cyc(1);
		sense_mode <= 1'b1;
		cause(0, 1600);
		chk_rst(1'b0);
		cause(1, 1510);
		chk_rst(1'b1);
		clear();
		chk_hold();
		cyc(1);
		sense_mode <= 1'b0;
		cause(2, 60);
		clear();
		cyc(1000);
		chk_rst(1'b1);
		cause(2, 60);
		clear();
		chk_hold();
		cyc(1);
		timeout_option <= SRS_TIMEOUT_OPTION_1;
		cause(2, 60);
		clear();
		chk_hold();
		cyc(1);
		timeout_option <= SRS_TIMEOUT_OPTION_0;
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		chk_rst(1'b1);
		chk_hold();
		test_done();
	end
endmodule
